// ==== logic/i2c_status_flags.sv ====
// Status flag logic of the I2C controller with register port and interrupt
`timescale 1ns/1ps
module i2c_status_flags
   import flag_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic [flag_pkg::ADDR_W-1:0] addr,
   input  wire logic [flag_pkg::DATA_W-1:0] wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic [flag_pkg::DATA_W-1:0]  rdata,
   input  wire logic                    master_active,
   input  wire logic                    master_fifo_empty,
   input  wire logic                    last_byte_stop,
   input  wire logic                    master_fifo_write,
   input  wire logic                    ack_sample,
   input  wire logic                    ack_missing,
   input  wire logic                    transmitting,
   input  wire logic                    own_data_line_drive,
   input  wire logic                    sda_in,
   input  wire logic                    transaction_done,
   input  wire logic                    slave_mode,
   input  wire logic                    slave_tx_active,
   input  wire logic                    slave_fifo_empty,
   input  wire logic                    slave_last_acked,
   input  wire logic                    slave_fifo_write,
   output logic [flag_pkg::FLAG_N-1:0]  bus_status_flags,
   output logic                         hold_scl_low,
   output logic                         irq
);
   import flag_pkg::*;

   typedef struct packed {
      flags_type           status;
      logic                hold;
      logic [DATA_W-1:0]   rdata;
   } flag_state_type;

   flag_state_type st_reg;
   flag_state_type st_next;

   flag_evt_if ev ();

   logic master_starved;
   logic slave_starved;
   logic arb_lost;
   logic master_done;
   logic nack_seen;
   logic status_wr;
   logic mask_hit_wr;
   logic event_rd;

   always_comb begin
      // Master transmitter out of data mid-transfer
      master_starved = master_active & master_fifo_empty & ~last_byte_stop;
      slave_starved  = slave_tx_active & slave_fifo_empty & slave_last_acked;
      arb_lost       = transmitting & own_data_line_drive & ~sda_in;
      master_done    = transaction_done & ~slave_mode;
      nack_seen      = ack_sample & ack_missing;
      status_wr      = wr && (addr == STATUS_ADDR);
      mask_hit_wr    = wr && (addr == MASK_ADDR);
      event_rd       = rd && (addr == EVENT_ADDR);
   end

   always_comb begin
      st_next = st_reg;

      // Starvation flags set on their condition and hold until a FIFO write; the write wins since
      // the condition still shows empty in the write cycle and would re-set it.
      st_next.status[MDR_BIT] = (st_reg.status[MDR_BIT] | master_starved) & ~master_fifo_write;
      st_next.status[SDR_BIT] = (st_reg.status[SDR_BIT] | slave_starved) & ~slave_fifo_write;

      // No-ack: only a master FIFO write clears, a new miss wins
      st_next.status[NACK_BIT] = (st_reg.status[NACK_BIT] & ~master_fifo_write) | nack_seen;

      // Write-one-to-clear flags; zero bits in the write leave them alone
      st_next.status[ARB_BIT] = (st_reg.status[ARB_BIT] & ~(status_wr & wdata[ARB_BIT])) | arb_lost;
      st_next.status[DONE_BIT] = (st_reg.status[DONE_BIT] & ~(status_wr & wdata[DONE_BIT])) | master_done;

      // Clock stretch whenever either transmitter is starved
      st_next.hold = st_next.status[MDR_BIT] | st_next.status[SDR_BIT];

      // Read data valid only in the cycle after the strobe
      st_next.rdata = RDATA_RST;
      if (rd) begin
         case (addr)
            STATUS_ADDR: st_next.rdata = {{(DATA_W-FLAG_N){1'b0}}, st_reg.status};
            MASK_ADDR:   st_next.rdata = {{(DATA_W-FLAG_N){1'b0}}, ev.mask};
            EVENT_ADDR:  st_next.rdata = {{(DATA_W-FLAG_N){1'b0}}, ev.pending};
            default:     st_next.rdata = RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{status: STATUS_RST, hold: 1'b0, rdata: RDATA_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   // Rising flags become interrupt events
   assign ev.evt        = st_next.status & ~st_reg.status;
   assign ev.mask_wr    = mask_hit_wr;
   assign ev.mask_wdata = wdata[FLAG_N-1:0];
   assign ev.clr_rd     = event_rd;

   irq_event_unit #(
      .EVT_N (FLAG_N)
   ) u_irq (
      .clk   (clk),
      .rst_n (rst_n),
      .ev    (ev)
   );

   assign rdata            = st_reg.rdata;
   assign bus_status_flags = st_reg.status;
   assign hold_scl_low     = st_reg.hold;
   assign irq              = ev.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   mdr_set_a: assert property (master_starved && !master_fifo_write |=> bus_status_flags[MDR_BIT])
      else $error("master data request not set while starved");

   scl_hold_a: assert property (master_starved && !master_fifo_write |=> hold_scl_low)
      else $error("SCL not held with master starved");

   hold_release_a: assert property (hold_scl_low && master_fifo_write && !slave_starved
      && !bus_status_flags[SDR_BIT] |=> !hold_scl_low)
      else $error("SCL hold not released after master FIFO write");

   mdr_clear_a: assert property (master_fifo_write |=> !bus_status_flags[MDR_BIT])
      else $error("master data request survived a FIFO write");

   nack_set_a: assert property (nack_seen |=> bus_status_flags[NACK_BIT])
      else $error("missing acknowledge not flagged");

   nack_keep_a: assert property (bus_status_flags[NACK_BIT] && !master_fifo_write
      |=> bus_status_flags[NACK_BIT])
      else $error("no-ack flag cleared without FIFO write");

   nack_clear_a: assert property (bus_status_flags[NACK_BIT] && master_fifo_write && !nack_seen
      |=> !bus_status_flags[NACK_BIT])
      else $error("no-ack flag not cleared by FIFO write");

   arb_set_a: assert property (arb_lost |=> bus_status_flags[ARB_BIT])
      else $error("lost arbitration not flagged");

   arb_clear_a: assert property (status_wr && wdata[ARB_BIT] && !arb_lost
      |=> !bus_status_flags[ARB_BIT])
      else $error("arbitration flag not cleared by write of one");

   done_set_a: assert property (master_done |=> bus_status_flags[DONE_BIT])
      else $error("transaction done not flagged");

   done_clear_a: assert property (status_wr && wdata[DONE_BIT] && !master_done
      |=> !bus_status_flags[DONE_BIT])
      else $error("done flag not cleared by write of one");

   slave_done_a: assert property (transaction_done && slave_mode && !(status_wr && wdata[DONE_BIT])
      |=> bus_status_flags[DONE_BIT] == $past(bus_status_flags[DONE_BIT]))
      else $error("slave transaction changed done flag");

   sdr_set_a: assert property (slave_starved && !slave_fifo_write
      |=> bus_status_flags[SDR_BIT] && hold_scl_low)
      else $error("slave starvation not flagged or SCL not held");

   sdr_clear_a: assert property (slave_fifo_write |=> !bus_status_flags[SDR_BIT])
      else $error("slave data request survived a FIFO write");

   zero_write_a: assert property (status_wr && bus_status_flags[ARB_BIT] && !wdata[ARB_BIT]
      |=> bus_status_flags[ARB_BIT])
      else $error("zero write cleared arbitration flag");

   fifo_bits_a: assert property (status_wr && !master_fifo_write && !slave_fifo_write
      |=> bus_status_flags[NACK_BIT] >= $past(bus_status_flags[NACK_BIT]))
      else $error("register write cleared a FIFO-cleared flag");

   status_read_a: assert property (rd && addr == STATUS_ADDR |=> rdata[FLAG_N-1:0] == $past(bus_status_flags)
      ##1 rdata == RDATA_RST || $past(rd))
      else $error("status read data wrong or not one cycle");

   irq_event_a: assert property (master_done && !bus_status_flags[DONE_BIT] && ev.mask[DONE_BIT] && !event_rd
      && !mask_hit_wr |=> irq)
      else $error("masked-in done event did not raise interrupt");

   stretch_c: cover property (master_starved ##1 hold_scl_low [*3] ##1 master_fifo_write ##1 !hold_scl_low);
   arb_c:     cover property (arb_lost ##1 status_wr && wdata[ARB_BIT] ##1 !bus_status_flags[ARB_BIT]);
   nack_c:    cover property (nack_seen ##1 bus_status_flags[NACK_BIT] ##[1:4] master_fifo_write);
   irq_c:     cover property (irq ##1 event_rd ##1 rdata != RDATA_RST);
endmodule // i2c_status_flags

// ==== include/flag_pkg.sv ====
// Constants and types for the I2C status flag logic
// Behaviour
// - The master data request flag (status bit 3) is set while a started master transmitter has no data left.
// - With the master transmit FIFO empty and no stop flag on the last byte, SCL is held low until a byte arrives.
// - A write into the master transmit FIFO clears the master data request flag.
// - After each sent byte the acknowledge is sampled and a missing one sets the no-ack flag (status bit 2).
// - Only a write into the master transmit FIFO clears the no-ack flag.
// - While transmitting, SDA sampled low while the own drive is high sets the arbitration lost flag (bit 1).
// - Writing a one to status bit 1 clears the arbitration lost flag.
// - A successful master transaction sets the transaction done flag (status bit 0).
// - Writing a one to status bit 0 clears the transaction done flag.
// - A transaction finished as slave leaves the transaction done flag unchanged.
// - The slave data request flag reads one from its set condition until a write into the slave transmit FIFO clears it.
// - Empty slave FIFO after an acknowledged byte sets the slave data request flag (bit 4) and holds SCL low.
package flag_pkg;
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 32;
   localparam int          FLAG_N      = 5;
   localparam logic [31:0] STATUS_ADDR = 32'hE0100304;
   localparam logic [31:0] MASK_ADDR   = 32'hE0100310;
   localparam logic [31:0] EVENT_ADDR  = 32'hE0100314;
   localparam int          DONE_BIT    = 0;
   localparam int          ARB_BIT     = 1;
   localparam int          NACK_BIT    = 2;
   localparam int          MDR_BIT     = 3;
   localparam int          SDR_BIT     = 4;
   localparam logic [4:0]  STATUS_RST  = 5'h00;
   localparam logic [4:0]  MASK_RST    = 5'h00;
   localparam logic [4:0]  EVENT_RST   = 5'h00;
   localparam logic [31:0] RDATA_RST   = 32'h00000000;
   typedef logic [FLAG_N-1:0] flags_type;
endpackage

// ==== include/flag_evt_if.sv ====
// Carrier between the status flag logic and its interrupt unit
`timescale 1ns/1ps
interface flag_evt_if;
   import flag_pkg::*;
   flags_type evt;
   flags_type mask_wdata;
   logic      mask_wr;
   logic      clr_rd;
   flags_type pending;
   flags_type mask;
   logic      irq;
   modport src  (output evt, mask_wdata, mask_wr, clr_rd, input pending, mask, irq);
   modport unit (input evt, mask_wdata, mask_wr, clr_rd, output pending, mask, irq);
endinterface

// ==== logic/irq_event_unit.sv ====
// Sticky event bits, mask and level interrupt
`timescale 1ns/1ps
module irq_event_unit
   import flag_pkg::*;
#(
   parameter int EVT_N = FLAG_N
) (
   input  wire logic clk,
   input  wire logic rst_n,
   flag_evt_if.unit  ev
);
   import flag_pkg::*;

   typedef struct packed {
      flags_type pending;
      flags_type mask;
      logic      irq;
   } unit_state_type;

   unit_state_type st_reg;
   unit_state_type st_next;

   if (EVT_N != FLAG_N) begin : g_chk
      $error("irq_event_unit: EVT_N must equal FLAG_N");
   end

   always_comb begin
      st_next = st_reg;
      if (ev.mask_wr) begin
         st_next.mask = ev.mask_wdata;
      end
      // New events win over the read that clears
      st_next.pending = (st_reg.pending & ~{FLAG_N{ev.clr_rd}}) | ev.evt;
      st_next.irq = |(st_next.pending & st_next.mask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{pending: EVENT_RST, mask: MASK_RST, irq: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign ev.pending = st_reg.pending;
   assign ev.mask    = st_reg.mask;
   assign ev.irq     = st_reg.irq;

   irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      ev.irq == |(ev.pending & ev.mask)) else $error("irq level does not follow pending and mask");
endmodule // irq_event_unit

// ==== bench/bus_partner.sv ====
// Far-side model: other devices sharing the open-drain SDA line
`timescale 1ns/1ps
module bus_partner (
   input  wire logic own_data_line_drive,
   input  wire logic pull_low,
   input  wire logic nack_req,
   input  wire logic ack_sample,
   output logic      sda_in,
   output logic      ack_missing
);
   // Pull-up line: another party can only pull it low, never push it high
   assign sda_in      = own_data_line_drive & ~pull_low;
   // Receiver leaves the line released only when told to refuse the byte
   assign ack_missing = ack_sample & nack_req;
endmodule // bus_partner

// ==== bench/tb.sv ====
// Self-checking bench for the status flag logic
`timescale 1ns/1ps
module tb;
   import flag_pkg::*;
   logic        clk, rst_n, wr, rd, master_active, master_fifo_empty, last_byte_stop, master_fifo_write;
   logic        ack_sample, ack_missing, transmitting, own_data_line_drive, sda_in, transaction_done;
   logic        slave_mode, slave_tx_active, slave_fifo_empty, slave_last_acked, slave_fifo_write;
   logic        pull_low, nack_req, hold_scl_low, irq, rd_seen;
   logic [31:0] addr, wdata, rdata, rdq[$];
   logic [4:0]  bus_status_flags;
   logic [5:0]  exp_f;
   int          n_fail, n_tests;

   i2c_status_flags i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .master_active(master_active), .master_fifo_empty(master_fifo_empty), .last_byte_stop(last_byte_stop),
      .master_fifo_write(master_fifo_write), .ack_sample(ack_sample), .ack_missing(ack_missing),
      .transmitting(transmitting), .own_data_line_drive(own_data_line_drive), .sda_in(sda_in),
      .transaction_done(transaction_done), .slave_mode(slave_mode), .slave_tx_active(slave_tx_active),
      .slave_fifo_empty(slave_fifo_empty), .slave_last_acked(slave_last_acked),
      .slave_fifo_write(slave_fifo_write), .bus_status_flags(bus_status_flags),
      .hold_scl_low(hold_scl_low), .irq(irq));

   bus_partner i_far (.own_data_line_drive(own_data_line_drive), .pull_low(pull_low), .nack_req(nack_req),
      .ack_sample(ack_sample), .sda_in(sda_in), .ack_missing(ack_missing));

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Flags with the SCL hold in bit 5
   task automatic cf(logic [5:0] e);
      chk("flags_hold", {26'h0, e}, {26'h0, hold_scl_low, bus_status_flags});
   endtask

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic wreg(logic [31:0] a, logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rreg(logic [31:0] a, logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      rdq.push_back(e);
      @(posedge clk);
      rd   <= 1'b0;
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_seen) chk("rdata", rdq.pop_front(), rdata);
      rd_seen <= rd;
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      results;
   end

   initial begin
      {rst_n, wr, rd, master_active, master_fifo_empty, last_byte_stop, master_fifo_write} = '0;
      {ack_sample, transmitting, own_data_line_drive, transaction_done, slave_mode} = '0;
      {slave_tx_active, slave_fifo_empty, slave_last_acked, slave_fifo_write, pull_low, nack_req} = '0;
      {addr, wdata, rd_seen, exp_f} = '0;
      void'($urandom(65));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      tick;
      cf(6'h00);
      rreg(STATUS_ADDR, 32'h0);
      rreg(MASK_ADDR, 32'h0);
      rreg(STATUS_ADDR + 32'h100 + ($urandom % 8) * 4, 32'h0);
      wreg(MASK_ADDR, {$urandom} | 32'h1F);
      rreg(MASK_ADDR, 32'h1F);
      @(posedge clk);
      master_active     <= 1'b1;
      master_fifo_empty <= 1'b1;
      tick;
      cf(6'h28);
      wreg(STATUS_ADDR, 32'h1C);
      #1 cf(6'h28);
      @(posedge clk);
      master_fifo_write <= 1'b1;
      master_fifo_empty <= 1'b0;
      @(posedge clk);
      master_fifo_write <= 1'b0;
      master_active     <= 1'b0;
      #1 cf(6'h00);
      chk("irq", 32'h1, {31'h0, irq});
      // Random acknowledge outcomes, then one sure refusal
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         ack_sample <= 1'b1;
         nack_req   <= (i == 4) ? 1'b1 : 1'($urandom % 2);
         @(posedge clk);
         ack_sample <= 1'b0;
         #1 exp_f[2] = exp_f[2] | nack_req;
         cf(exp_f);
      end
      wreg(STATUS_ADDR, 32'h4);
      #1 cf(6'h04);
      @(posedge clk);
      master_fifo_write <= 1'b1;
      @(posedge clk);
      master_fifo_write <= 1'b0;
      #1 cf(6'h00);
      @(posedge clk);
      transmitting <= 1'b1;
      pull_low     <= 1'b1;
      tick;
      cf(6'h00);
      @(posedge clk);
      own_data_line_drive <= 1'b1;
      tick;
      cf(6'h02);
      @(posedge clk);
      transmitting <= 1'b0;
      pull_low     <= 1'b0;
      wreg(STATUS_ADDR, 32'h0);
      #1 cf(6'h02);
      wreg(STATUS_ADDR, 32'h2);
      #1 cf(6'h00);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         slave_mode       <= (i == 0);
         transaction_done <= 1'b1;
         @(posedge clk);
         transaction_done <= 1'b0;
         #1 cf({5'h0, 1'(i)});
      end
      wreg(STATUS_ADDR, 32'h1);
      #1 cf(6'h00);
      @(posedge clk);
      slave_tx_active  <= 1'b1;
      slave_fifo_empty <= 1'b1;
      slave_last_acked <= 1'b1;
      tick;
      cf(6'h30);
      @(posedge clk);
      slave_fifo_write <= 1'b1;
      slave_fifo_empty <= 1'b0;
      @(posedge clk);
      slave_fifo_write <= 1'b0;
      slave_tx_active  <= 1'b0;
      #1 cf(6'h00);
      rreg(EVENT_ADDR, 32'h1F);
      tick;
      tick;
      chk("irq", 32'h0, {31'h0, irq});
      // Masked event still lands in pending but keeps the line low
      wreg(MASK_ADDR, 32'h0);
      @(posedge clk);
      transaction_done <= 1'b1;
      @(posedge clk);
      transaction_done <= 1'b0;
      tick;
      chk("irq", 32'h0, {31'h0, irq});
      rreg(EVENT_ADDR, 32'h1);
      wreg(STATUS_ADDR, 32'h1);
      tick;
      results;
   end
endmodule // tb
